// ---- src/ddcdm_pkg.sv ----
// package: constants and carrier types for the down-conversion datapath
package ddcdm_pkg;
    localparam int SAMPLE_W = 14;
    localparam int WORD_W = 16;
    localparam int PHASE_W = 16;
    localparam int LUT_BITS = 6;
    localparam int LUT_DEPTH = 64;
    localparam int ACC_W = 40;
    localparam int OUT_W = 16;
    localparam int CNT_W = 6;
    localparam int FIFO_DEPTH = 8;
    localparam int CHAINS = 4;
    localparam int CLK_MHZ = 125;
    localparam int NCO_SEL_W = 2;
    localparam int LAT_W = 12;
    localparam int LAT_HALF_W = 1;

    // decimation setting codes
    typedef enum logic [3:0] {
        DEC_BYPASS = 4'h0,
        DEC_4 = 4'h1,
        DEC_6 = 4'h2,
        DEC_8 = 4'h3,
        DEC_9 = 4'h4,
        DEC_10 = 4'h5,
        DEC_12 = 4'h6,
        DEC_16 = 4'h7,
        DEC_18 = 4'h8,
        DEC_20 = 4'h9,
        DEC_24 = 4'ha,
        DEC_32 = 4'hb
    } ddcdm_dec_t;

    // ddc configuration, only one active at a time
    typedef enum logic [1:0] {
        CFG_SINGLE = 2'h0,
        CFG_DUAL = 2'h1,
        CFG_WIDE = 2'h2
    } ddcdm_cfg_t;

    // flush state of the first chain after an oscillator switch
    typedef enum logic [1:0] {
        FL_IDLE = 2'h0,
        FL_FLUSH = 2'h1
    } ddcdm_flush_t;

    localparam logic [CNT_W-1:0] RATIO_4 = 6'h04;
    localparam logic [CNT_W-1:0] RATIO_6 = 6'h06;
    localparam logic [CNT_W-1:0] RATIO_8 = 6'h08;
    localparam logic [CNT_W-1:0] RATIO_9 = 6'h09;
    localparam logic [CNT_W-1:0] RATIO_10 = 6'h0a;
    localparam logic [CNT_W-1:0] RATIO_12 = 6'h0c;
    localparam logic [CNT_W-1:0] RATIO_16 = 6'h10;
    localparam logic [CNT_W-1:0] RATIO_18 = 6'h12;
    localparam logic [CNT_W-1:0] RATIO_20 = 6'h14;
    localparam logic [CNT_W-1:0] RATIO_24 = 6'h18;
    localparam logic [CNT_W-1:0] RATIO_32 = 6'h20;

    // total sample-to-output latency in device clocks; the 9 setting adds a half
    localparam logic [LAT_W-1:0] LAT_BYPASS = 12'h1a8;
    localparam logic [LAT_W-1:0] LAT_4 = 12'h204;
    localparam logic [LAT_W-1:0] LAT_6 = 12'h2ea;
    localparam logic [LAT_W-1:0] LAT_8 = 12'h26d;
    localparam logic [LAT_W-1:0] LAT_9 = 12'h2fb;
    localparam logic [LAT_W-1:0] LAT_10 = 12'h32b;
    localparam logic [LAT_W-1:0] LAT_12 = 12'h381;
    localparam logic [LAT_W-1:0] LAT_16 = 12'h415;
    localparam logic [LAT_W-1:0] LAT_18 = 12'h48c;
    localparam logic [LAT_W-1:0] LAT_20 = 12'h4e8;
    localparam logic [LAT_W-1:0] LAT_24 = 12'h5a3;
    localparam logic [LAT_W-1:0] LAT_32 = 12'h6ed;

    localparam logic [NCO_SEL_W-1:0] SEL_NONE = 2'h3;
    localparam logic [ACC_W-1:0] ACC_ZERO = 40'h0;
    localparam int OUT_SHIFT = 14;

    typedef struct packed {
        logic signed [OUT_W-1:0] re;
        logic signed [OUT_W-1:0] im;
    } ddcdm_cplx_t;

    typedef struct packed {
        logic [1:0] chain;
        logic real_fmt;
        ddcdm_cplx_t smp;
    } ddcdm_word_t;
endpackage

// ---- src/ddcdm_top.sv ----
// file: down-conversion datapath with oscillators, mixers, decimators and output fifo
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - eleven complex decimation ratios, four to thirty-two
// - filters are boxcar averages, far below 90 dB stop
// - alias bands attenuated far less than 90 dB (boxcar)
// - divide-by-4 gives quarter-rate complex stream
// - passband droop of the boxcar well above 0.39 dB
// - bypass latency is 424 device clocks
// - latency per ratio as tabulated
// - mux mode feeds channel A to all four chains
// - mux mode: one channel, four chains
// - chain one three oscillators, chain two one
// - chain one oscillator chosen by pin/register
// - wideband ratios allow one chain only
// - oscillator frequency from signed 16-bit word
// - mixer multiplies sample by complex oscillator
// - frequency equals word times rate over 65536
// - live register change leaves phase non-deterministic
// - bypass powers down all oscillators
// - optional real output flag; words stay complex at the same rate
// - oscillators run on; flush after switch
// - both chains share one decimation setting
// - only one ddc configuration enabled

// ----------------------------------------------------------------
// fifo
// ----------------------------------------------------------------
module ddcdm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wr_r;
    logic [AW:0] rd_r;
    logic full;
    logic empty;
    assign full = (wr_r[AW-1:0] == rd_r[AW-1:0]) && (wr_r[AW] != rd_r[AW]);
    assign empty = (wr_r == rd_r);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem_r[rd_r[AW-1:0]];
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_r <= '0;
        end else if (in_valid_i && !full) begin
            wr_r <= wr_r + 1'b1;
        end
    end
    always_ff @(posedge clock_i) begin
        if (in_valid_i && !full) begin
            mem_r[wr_r[AW-1:0]] <= in_data_i;
        end
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rd_r <= '0;
        end else if (out_ready_i && !empty) begin
            rd_r <= rd_r + 1'b1;
        end
    end
endmodule

// ----------------------------------------------------------------
// top
// ----------------------------------------------------------------
module ddcdm_top (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic sample_valid_i,
    input wire logic signed [ddcdm_pkg::SAMPLE_W-1:0] sample_a_i,
    input wire logic signed [ddcdm_pkg::SAMPLE_W-1:0] sample_b_i,
    input wire logic [3:0] dec_setting_i,
    input wire logic [1:0] ddc_config_i,
    input wire logic mux_mode_i,
    input wire logic real_out_i,
    input wire logic nco_sel_from_pin_i,
    input wire logic [ddcdm_pkg::NCO_SEL_W-1:0] nco_sel_reg_i,
    input wire logic [ddcdm_pkg::NCO_SEL_W-1:0] nco_sel_pin_i,
    input wire logic [ddcdm_pkg::WORD_W*8-1:0] mixer_frequency_word_i,
    output logic nco_powered_o,
    output logic chain1_enabled_o,
    output logic flushing_o,
    output logic [ddcdm_pkg::LAT_W-1:0] latency_o,
    output logic latency_half_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [1:0] out_chain_o,
    output logic out_real_o,
    output logic [ddcdm_pkg::OUT_W*2-1:0] out_data_o,
    output logic stall_o
);
    localparam int PW = ddcdm_pkg::PHASE_W;
    localparam int LB = ddcdm_pkg::LUT_BITS;
    localparam int AW = ddcdm_pkg::ACC_W;
    localparam int OW = ddcdm_pkg::OUT_W;
    localparam int SW = ddcdm_pkg::SAMPLE_W;
    localparam int FW = $bits(ddcdm_pkg::ddcdm_word_t);

    ddcdm_pkg::ddcdm_dec_t dec;
    ddcdm_pkg::ddcdm_cfg_t cfg;
    logic bypass;
    logic wide;
    logic [ddcdm_pkg::CNT_W-1:0] ratio;
    logic fifo_ready;
    logic run;
    assign dec = ddcdm_pkg::ddcdm_dec_t'(dec_setting_i);
    assign cfg = ddcdm_pkg::ddcdm_cfg_t'(ddc_config_i);
    assign bypass = (dec == ddcdm_pkg::DEC_BYPASS);
    assign wide = (dec == ddcdm_pkg::DEC_4) || (dec == ddcdm_pkg::DEC_6);
    assign nco_powered_o = !bypass;
    // second chain only in dual-band, never in wideband ratios
    assign chain1_enabled_o = (cfg == ddcdm_pkg::CFG_DUAL) && !wide;
    // back-pressure from the fifo freezes the decimating datapath; bypass samples arriving while it is full are dropped
    assign run = sample_valid_i && fifo_ready;
    assign stall_o = !fifo_ready;

    // one ratio and latency shared by every chain
    always_comb begin
        ratio = ddcdm_pkg::RATIO_4;
        latency_o = ddcdm_pkg::LAT_BYPASS;
        latency_half_o = 1'b0;
        case (dec)
            ddcdm_pkg::DEC_4: begin
                ratio = ddcdm_pkg::RATIO_4;
                latency_o = ddcdm_pkg::LAT_4;
            end
            ddcdm_pkg::DEC_6: begin
                ratio = ddcdm_pkg::RATIO_6;
                latency_o = ddcdm_pkg::LAT_6;
            end
            ddcdm_pkg::DEC_8: begin
                ratio = ddcdm_pkg::RATIO_8;
                latency_o = ddcdm_pkg::LAT_8;
            end
            ddcdm_pkg::DEC_9: begin
                ratio = ddcdm_pkg::RATIO_9;
                latency_o = ddcdm_pkg::LAT_9;
                latency_half_o = 1'b1;
            end
            ddcdm_pkg::DEC_10: begin
                ratio = ddcdm_pkg::RATIO_10;
                latency_o = ddcdm_pkg::LAT_10;
            end
            ddcdm_pkg::DEC_12: begin
                ratio = ddcdm_pkg::RATIO_12;
                latency_o = ddcdm_pkg::LAT_12;
            end
            ddcdm_pkg::DEC_16: begin
                ratio = ddcdm_pkg::RATIO_16;
                latency_o = ddcdm_pkg::LAT_16;
            end
            ddcdm_pkg::DEC_18: begin
                ratio = ddcdm_pkg::RATIO_18;
                latency_o = ddcdm_pkg::LAT_18;
            end
            ddcdm_pkg::DEC_20: begin
                ratio = ddcdm_pkg::RATIO_20;
                latency_o = ddcdm_pkg::LAT_20;
            end
            ddcdm_pkg::DEC_24: begin
                ratio = ddcdm_pkg::RATIO_24;
                latency_o = ddcdm_pkg::LAT_24;
            end
            ddcdm_pkg::DEC_32: begin
                ratio = ddcdm_pkg::RATIO_32;
                latency_o = ddcdm_pkg::LAT_32;
            end
            default: begin
                ratio = ddcdm_pkg::RATIO_4;
                latency_o = ddcdm_pkg::LAT_BYPASS;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // oscillators: 4 per channel (three for chain 0, one for chain 1)
    // ----------------------------------------------------------------
    logic [PW-1:0] phase_r [8];
    logic signed [OW-1:0] cos_lut [ddcdm_pkg::LUT_DEPTH];
    logic signed [OW-1:0] sin_lut [ddcdm_pkg::LUT_DEPTH];
    // coarse quarter-wave free table; spur level is traded for area
    always_comb begin
        for (int k = 0; k < ddcdm_pkg::LUT_DEPTH; k++) begin
            cos_lut[k] = OW'($rtoi(16383.0 * $cos(6.283185307 * k / 64.0)));
            sin_lut[k] = OW'($rtoi(16383.0 * $sin(6.283185307 * k / 64.0)));
        end
    end
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_osc
            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    phase_r[g] <= '0;
                end else if (bypass) begin
                    phase_r[g] <= '0;
                end else if (run) begin
                    // all three chain-0 oscillators keep running for phase continuity
                    phase_r[g] <= phase_r[g] + mixer_frequency_word_i[g*PW +: PW];
                end
            end
        end
    endgenerate

    // chain-0 oscillator selection and flush tracking
    logic [ddcdm_pkg::NCO_SEL_W-1:0] sel_now;
    logic [ddcdm_pkg::NCO_SEL_W-1:0] sel_r;
    logic [ddcdm_pkg::CNT_W+1:0] flush_cnt_r;
    ddcdm_pkg::ddcdm_flush_t flush_r;
    logic dump0;
    assign sel_now = nco_sel_from_pin_i ? nco_sel_pin_i : nco_sel_reg_i;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sel_r <= '0;
        end else if (sel_now != ddcdm_pkg::SEL_NONE) begin
            sel_r <= sel_now;
        end
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            flush_r <= ddcdm_pkg::FL_IDLE;
            flush_cnt_r <= '0;
        end else begin
            case (flush_r)
                ddcdm_pkg::FL_IDLE: begin
                    if (sel_now != ddcdm_pkg::SEL_NONE && sel_now != sel_r) begin
                        flush_r <= ddcdm_pkg::FL_FLUSH;
                        flush_cnt_r <= '0;
                    end
                end
                ddcdm_pkg::FL_FLUSH: begin
                    // a restart if the selection moves again mid-flush
                    if (sel_now != ddcdm_pkg::SEL_NONE && sel_now != sel_r) begin
                        flush_cnt_r <= '0;
                    end else if (dump0) begin
                        flush_cnt_r <= flush_cnt_r + 1'b1;
                        if (flush_cnt_r == 8'(1)) begin
                            flush_r <= ddcdm_pkg::FL_IDLE;
                        end
                    end
                end
                default: flush_r <= ddcdm_pkg::FL_IDLE;
            endcase
        end
    end
    assign flushing_o = (flush_r == ddcdm_pkg::FL_FLUSH);

    // ----------------------------------------------------------------
    // mixers and integrate-and-dump decimators, four chains
    // ----------------------------------------------------------------
    logic signed [SW-1:0] src [ddcdm_pkg::CHAINS];
    logic [PW-1:0] ph [ddcdm_pkg::CHAINS];
    logic en [ddcdm_pkg::CHAINS];
    logic signed [AW-1:0] acc_re_r [ddcdm_pkg::CHAINS];
    logic signed [AW-1:0] acc_im_r [ddcdm_pkg::CHAINS];
    logic [ddcdm_pkg::CNT_W-1:0] cnt_r;
    logic pend_r [ddcdm_pkg::CHAINS];
    ddcdm_pkg::ddcdm_cplx_t res_r [ddcdm_pkg::CHAINS];
    assign dump0 = run && !bypass && (cnt_r == ratio - 1'b1);
    always_comb begin
        for (int c = 0; c < ddcdm_pkg::CHAINS; c++) begin
            // mux mode routes channel A into channel B's chains too
            src[c] = (c >= 2 && !mux_mode_i) ? sample_b_i : sample_a_i;
        end
        ph[0] = phase_r[sel_r];
        ph[1] = phase_r[3];
        ph[2] = phase_r[4 + 32'(sel_r)];
        ph[3] = phase_r[7];
        en[0] = 1'b1;
        en[1] = chain1_enabled_o;
        en[2] = 1'b1;
        en[3] = chain1_enabled_o;
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else if (bypass) begin
            cnt_r <= '0;
        end else if (run) begin
            cnt_r <= (cnt_r == ratio - 1'b1) ? '0 : cnt_r + 1'b1;
        end
    end
    generate
        for (g = 0; g < ddcdm_pkg::CHAINS; g++) begin : g_chain
            logic signed [SW+OW-1:0] m_re;
            logic signed [SW+OW-1:0] m_im;
            // e^-jwn: cosine and negative sine
            assign m_re = src[g] * cos_lut[ph[g][PW-1 -: LB]];
            assign m_im = -(src[g] * sin_lut[ph[g][PW-1 -: LB]]);
            // boxcar average: alias rejection is far below a full fir, kept for area
            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    acc_re_r[g] <= ddcdm_pkg::ACC_ZERO;
                    acc_im_r[g] <= ddcdm_pkg::ACC_ZERO;
                    res_r[g] <= '0;
                    pend_r[g] <= 1'b0;
                end else begin
                    if (run && !bypass) begin
                        if (dump0) begin
                            acc_re_r[g] <= ddcdm_pkg::ACC_ZERO;
                            acc_im_r[g] <= ddcdm_pkg::ACC_ZERO;
                            res_r[g].re <= OW'((acc_re_r[g] + m_re) / $signed({1'b0, ratio}) >>> ddcdm_pkg::OUT_SHIFT);
                            res_r[g].im <= OW'((acc_im_r[g] + m_im) / $signed({1'b0, ratio}) >>> ddcdm_pkg::OUT_SHIFT);
                        end else begin
                            acc_re_r[g] <= acc_re_r[g] + AW'(m_re);
                            acc_im_r[g] <= acc_im_r[g] + AW'(m_im);
                        end
                    end
                    pend_r[g] <= dump0 && en[g] && !(g == 0 && flushing_o) && !(g == 2 && flushing_o);
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // output into fifo: only the lowest-numbered pending chain is written, the rest are dropped; bypass passes raw A and B
    // ----------------------------------------------------------------
    ddcdm_pkg::ddcdm_word_t fw;
    logic fv;
    always_comb begin
        fw = '0;
        fv = 1'b0;
        fw.real_fmt = real_out_i;
        if (bypass) begin
            fv = sample_valid_i;
            fw.smp.re = OW'(sample_a_i);
            fw.smp.im = OW'(sample_b_i);
        end else begin
            for (int c = ddcdm_pkg::CHAINS - 1; c >= 0; c--) begin
                if (pend_r[c]) begin
                    fv = 1'b1;
                    fw.chain = 2'(c);
                    fw.smp = res_r[c];
                end
            end
        end
    end
    // register changes reach the phase at once; the far side must re-sync the link
    ddcdm_fifo #(.WIDTH(FW), .DEPTH(ddcdm_pkg::FIFO_DEPTH)) u_fifo (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .in_valid_i(fv),
        .in_ready_o(fifo_ready),
        .in_data_i(fw),
        .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i),
        .out_data_o({out_chain_o, out_real_o, out_data_o})
    );
endmodule
`default_nettype wire

// ---- verification/ddcdm_assertions.sv ----
// checker: port-level properties of the down-conversion datapath
`timescale 1ns/1ps
`default_nettype none
module ddcdm_checker (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic sample_valid_i,
    input wire logic [3:0] dec_setting_i,
    input wire logic [1:0] ddc_config_i,
    input wire logic nco_sel_from_pin_i,
    input wire logic [1:0] nco_sel_reg_i,
    input wire logic [1:0] nco_sel_pin_i,
    input wire logic nco_powered_o,
    input wire logic chain1_enabled_o,
    input wire logic flushing_o,
    input wire logic [11:0] latency_o,
    input wire logic latency_half_o,
    input wire logic out_valid_o,
    input wire logic out_ready_i,
    input wire logic [31:0] out_data_o,
    input wire logic stall_o
);
    localparam logic [11:0] LAT [12] = '{12'h1a8, 12'h204, 12'h2ea, 12'h26d, 12'h2fb, 12'h32b,
        12'h381, 12'h415, 12'h48c, 12'h4e8, 12'h5a3, 12'h6ed};
    logic [1:0] sel;
    assign sel = nco_sel_from_pin_i ? nco_sel_pin_i : nco_sel_reg_i;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence s_byp_take; dec_setting_i == 4'h0 && sample_valid_i && !stall_o && !flushing_o; endsequence
    // code 3 selects nothing, so only moves between real oscillators count as switches
    sequence s_switch; dec_setting_i != 4'h0 && sel != 2'h3 && $past(sel) != 2'h3 && sel != $past(sel); endsequence
    sequence s_wait; out_valid_o && !out_ready_i; endsequence

    property p_nco_pwr; nco_powered_o == (dec_setting_i != 4'h0); endproperty
    a_nco_pwr: assert property (p_nco_pwr) else $error("oscillator power wrong");
    property p_lat; dec_setting_i <= 4'hb |-> latency_o == LAT[dec_setting_i]; endproperty
    a_lat: assert property (p_lat) else $error("latency figure wrong");
    property p_lat_half; latency_half_o == (dec_setting_i == 4'h4); endproperty
    a_lat_half: assert property (p_lat_half) else $error("half-cycle latency flag wrong");
    property p_wide_one; dec_setting_i inside {4'h1, 4'h2} |-> !chain1_enabled_o; endproperty
    a_wide_one: assert property (p_wide_one) else $error("second chain on at wide ratio");
    property p_cfg_one; ddc_config_i != 2'h1 |-> !chain1_enabled_o; endproperty
    a_cfg_one: assert property (p_cfg_one) else $error("second chain on outside dual");
    property p_dual; ddc_config_i == 2'h1 && dec_setting_i inside {[4'h3:4'hb]} |-> chain1_enabled_o; endproperty
    a_dual: assert property (p_dual) else $error("second chain off in dual");
    property p_hold; s_wait |=> out_valid_o && $stable(out_data_o); endproperty
    a_hold: assert property (p_hold) else $error("output word moved before acceptance");
    property p_full; stall_o |-> out_valid_o; endproperty
    a_full: assert property (p_full) else $error("full without valid output");
    property p_byp; s_byp_take |-> ##[1:2] out_valid_o; endproperty
    a_byp: assert property (p_byp) else $error("bypass sample did not reach output");
    property p_flush; s_switch |-> ##[1:2] flushing_o; endproperty
    a_flush: assert property (p_flush) else $error("no flush after oscillator switch");
endmodule
bind ddcdm_top ddcdm_checker i_chk (
    .clock_i, .rst_i, .sample_valid_i, .dec_setting_i, .ddc_config_i, .nco_sel_from_pin_i,
    .nco_sel_reg_i, .nco_sel_pin_i, .nco_powered_o, .chain1_enabled_o, .flushing_o, .latency_o,
    .latency_half_o, .out_valid_o, .out_ready_i, .out_data_o, .stall_o
);
`default_nettype wire

// ---- verification/ddcdm_sink.sv ----
// far-side model: output framing that takes words promptly, slowly or not at all
`timescale 1ns/1ps
`default_nettype none
module ddcdm_sink (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [1:0] mode_i,
    output logic ready_o
);
    logic [7:0] lfsr_r;
    // slow mode drops ready on a pseudo-random pattern so the fifo sees back-pressure
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            lfsr_r <= 8'h5a;
            ready_o <= 1'b0;
        end else begin
            lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
            ready_o <= (mode_i == 2'h0) || (mode_i == 2'h1 && lfsr_r[0]);
        end
    end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// testbench: random stimulus against a counting model of the datapath
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic sample_valid_i = 1'b0;
    logic signed [13:0] sample_a_i = 14'h0000;
    logic signed [13:0] sample_b_i = 14'h0000;
    logic [3:0] dec_setting_i = 4'h0;
    logic [1:0] ddc_config_i = 2'h0;
    logic mux_mode_i = 1'b0;
    logic real_out_i = 1'b0;
    logic nco_sel_from_pin_i = 1'b0;
    logic [1:0] nco_sel_reg_i = 2'h0;
    logic [1:0] nco_sel_pin_i = 2'h0;
    logic [127:0] mixer_frequency_word_i = 128'h0;
    logic nco_powered_o, chain1_enabled_o, flushing_o, latency_half_o, out_valid_o, out_ready_i, out_real_o, stall_o;
    logic [11:0] latency_o;
    logic [1:0] out_chain_o;
    logic [31:0] out_data_o;
    logic [1:0] sink_mode = 2'h2;
    logic [31:0] seed = 32'h0000_9505;
    logic drive_on = 1'b0;
    logic chk_on = 1'b0;
    logic saw_stall = 1'b0;
    int err_total = 0;
    int comparisons = 0;
    int taken = 0;
    int ratio = 1;
    logic [32:0] q_exp[$];
    longint acc = 0;
    int rat[12] = '{1, 4, 6, 8, 9, 10, 12, 16, 18, 20, 24, 32};
    logic [11:0] lat[12] = '{12'h1a8, 12'h204, 12'h2ea, 12'h26d, 12'h2fb, 12'h32b,
        12'h381, 12'h415, 12'h48c, 12'h4e8, 12'h5a3, 12'h6ed};

    always #4 clock_i = ~clock_i;

    ddcdm_top i_dut (
        .clock_i, .rst_i, .sample_valid_i, .sample_a_i, .sample_b_i, .dec_setting_i, .ddc_config_i,
        .mux_mode_i, .real_out_i, .nco_sel_from_pin_i, .nco_sel_reg_i, .nco_sel_pin_i, .mixer_frequency_word_i,
        .nco_powered_o, .chain1_enabled_o, .flushing_o, .latency_o, .latency_half_o, .out_valid_o,
        .out_ready_i, .out_chain_o, .out_real_o, .out_data_o, .stall_o
    );
    ddcdm_sink i_sink (.clock_i, .rst_i, .mode_i(sink_mode), .ready_o(out_ready_i));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset(input int n);
        rst_i <= 1'b1;
        chk_on <= 1'b0;
        repeat (n) @(posedge clock_i);
        q_exp.delete();
        taken = 0;
        acc = 0;
        rst_i <= 1'b0;
    endtask

    task automatic wait_flush(input logic want, input int lim);
        int k;
        for (k = 0; k < lim && flushing_o !== want; k++) begin
            @(posedge clock_i);
            #1;
        end
        check(flushing_o, want);
        if (flushing_o !== want) results();
    endtask

    // ----------------------------------------------------------------
    // stimulus and model
    // ----------------------------------------------------------------
    always @(posedge clock_i) begin
        if (drive_on) begin
            seed = xs(seed);
            sample_valid_i <= seed[0] | seed[1];
            sample_a_i <= seed[29:16];
            sample_b_i <= seed[13:0];
        end else begin
            sample_valid_i <= 1'b0;
        end
    end

    // one expected word per ratio accepted samples; word 0 keeps the phase at zero, so im stays 0
    always @(posedge clock_i) begin
        if (!rst_i && chk_on) begin
            if (stall_o) saw_stall = 1'b1;
            if (sample_valid_i && !stall_o) begin
                taken++;
                acc += sample_a_i * 16383;
                if (taken == ratio) begin
                    taken = 0;
                    // bypass passes raw a and b; decimated word is the mean of a times the cosine peak, shifted right by 14
                    q_exp.push_back({real_out_i, ratio > 1 ? {16'(acc / ratio >>> 14), 16'h0000}
                        : {16'(sample_a_i), 16'(sample_b_i)}});
                    acc = 0;
                end
            end
            if (out_valid_o && out_ready_i) begin
                check(q_exp.size() > 0, 1);
                check(out_chain_o, 2'h0);
                check(out_real_o, q_exp[0][32]);
                check(out_data_o, q_exp[0][31:0]);
                void'(q_exp.pop_front());
            end
        end
    end

    initial begin
        int k;
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            dec_setting_i <= i[3:0];
            ddc_config_i <= 2'h1;
            real_out_i <= seed[2];
            mux_mode_i <= seed[3];
            mixer_frequency_word_i <= {seed, seed, seed, seed[31:16], 16'h0000};
            do_reset(i == 0 ? 10 : 3);
            @(posedge clock_i);
            #1;
            check(latency_o, lat[i]);
            check(latency_half_o, i == 4);
            check(nco_powered_o, i != 0);
            check(chain1_enabled_o, i == 0 || i >= 3);
            @(posedge clock_i);
            ddc_config_i <= 2'h2;
            #1;
            check(chain1_enabled_o, 1'b0);
            @(posedge clock_i);
            ddc_config_i <= 2'h0;
            ratio = rat[i];
            chk_on <= 1'b1;
            drive_on <= 1'b1;
            repeat (30) @(posedge clock_i);
            sink_mode <= 2'h1;
            repeat (rat[i] * 12) @(posedge clock_i);
            drive_on <= 1'b0;
            sink_mode <= 2'h0;
            for (k = 0; k < 600 && q_exp.size() > 0; k++) @(posedge clock_i);
            repeat (4) @(posedge clock_i);
            #1;
            check(q_exp.size(), 0);
            check(out_valid_o, 1'b0);
            if (q_exp.size() > 0) results();
            sink_mode <= 2'h2;
        end
        check(saw_stall, 1'b1);
        dec_setting_i <= 4'h3;
        do_reset(3);
        ratio = 8;
        drive_on <= 1'b1;
        sink_mode <= 2'h1;
        repeat (40) @(posedge clock_i);
        nco_sel_reg_i <= 2'h1;
        wait_flush(1'b1, 3);
        wait_flush(1'b0, 400);
        @(posedge clock_i);
        nco_sel_pin_i <= 2'h2;
        nco_sel_from_pin_i <= 1'b1;
        wait_flush(1'b1, 3);
        wait_flush(1'b0, 400);
        @(posedge clock_i);
        nco_sel_pin_i <= 2'h3;
        repeat (3) @(posedge clock_i);
        #1;
        check(flushing_o, 1'b0);
        drive_on <= 1'b0;
        results();
    end
endmodule
`default_nettype wire
